// ===== pkg/vtp_pkg.sv
// Purpose: Shared constants and types of the video test pattern block.
// Assumes: aclk is the parallel word clock.
// Notes:   Words are 10 bits, sent LSB first by the 10x bit serializer.
package vtp_pkg;
    // Word and bus widths.
    localparam int unsigned WORD_W = 10;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CODE_W = 4;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ERRCNT = 8'h08;
    localparam logic [7:0] REG_FIELDS = 8'h0C;
    // Control register fields.
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_SEL_BIT  = 1;
    localparam int unsigned CTRL_CODE_LSB = 4;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Pattern codes that run the self check.
    localparam logic [3:0] CODE_CHK_NTSC = 4'h3;
    localparam logic [3:0] CODE_CHK_PAL  = 4'h5;
    // Fields of error-free pattern before the pass flag rises.
    localparam logic [15:0] PASS_FIELDS = 16'h0002;
    // Words the descrambler needs before its output is trusted.
    localparam logic [2:0] WARM_WORDS = 3'h4;
    // Raster geometry in words per line.
    localparam logic [11:0] LINE_N43  = 12'h6B4;
    localparam logic [11:0] LINE_P43  = 12'h6C0;
    localparam logic [11:0] LINE_N169 = 12'h8F0;
    localparam logic [11:0] LINE_P169 = 12'h900;
    localparam logic [11:0] ACT_43    = 12'h5A0;
    localparam logic [11:0] ACT_169   = 12'h780;
    localparam logic [11:0] TRS_LEN   = 12'h004;
    localparam logic [7:0]  BARW_43   = 8'hB4;
    localparam logic [7:0]  BARW_169  = 8'hF0;
    // Word values.
    localparam logic [9:0] TRS_ONES  = 10'h3FF;
    localparam logic [9:0] TRS_ZERO  = 10'h000;
    localparam logic [9:0] XYZ_EAV   = 10'h274;
    localparam logic [9:0] XYZ_SAV   = 10'h200;
    localparam logic [9:0] BLACK_Y   = 10'h040;
    localparam logic [9:0] BLACK_C   = 10'h200;
    localparam logic [9:0] EQ_Y      = 10'h198;
    localparam logic [9:0] EQ_C      = 10'h300;
    localparam logic [9:0] PLL_Y     = 10'h110;
    localparam logic [9:0] PLL_C     = 10'h200;

    // Pattern kinds, in code order.
    typedef enum logic [1:0] {PAT_BLACK, PAT_PLL, PAT_EQ, PAT_BARS} vtp_pat_t;

    // Decoded pattern code; bit order matches code bits 3..0.
    typedef struct packed {
        logic     wide;
        logic     pal;
        vtp_pat_t pat;
    } vtp_mode_t;

    // True and complement serial words.
    typedef struct packed {
        logic [9:0] p;
        logic [9:0] n;
    } vtp_pair_t;

    // Scrambler or descrambler running state plus one word.
    typedef struct packed {
        logic [8:0] hist;
        logic       last;
        logic [9:0] word;
    } vtp_scr_t;
endpackage

// ===== src/vtp_pattern_gen.sv
// Purpose: Full-field component pattern source, one word per clock.
// Assumes: mode is stable while run is high.
// Notes:   Field pulse marks the last word of each field.
`timescale 1ns/1ps
`default_nettype none
module vtp_pattern_gen #(
    parameter int unsigned LINES_NTSC = 262,
    parameter int unsigned LINES_PAL  = 312
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              run,
    input  wire vtp_pkg::vtp_mode_t mode,
    output var  logic [9:0]        word_r,
    output var  logic              field_end_r
);
    import vtp_pkg::*;

    logic [11:0] h_r;
    logic [9:0]  v_r;
    logic [2:0]  bar_r;
    logic [7:0]  barc_r;

    // Geometry for the selected standard and raster.
    wire [11:0] total_w = mode.wide ? (mode.pal ? LINE_P169 : LINE_N169)
                                    : (mode.pal ? LINE_P43 : LINE_N43);
    wire [11:0] act_len_w = mode.wide ? ACT_169 : ACT_43;
    wire [7:0]  barw_w    = mode.wide ? BARW_169 : BARW_43;
    wire [9:0]  lines_w   = mode.pal ? 10'(LINES_PAL) : 10'(LINES_NTSC);
    wire [11:0] act_w     = total_w - act_len_w;
    wire [11:0] sav_w     = act_w - TRS_LEN;
    wire        h_last_w  = (h_r == total_w - 12'h001);
    wire        v_last_w  = (v_r == lines_w - 10'h001);
    wire        in_act_w  = (h_r >= act_w);
    wire        in_sav_w  = (h_r >= sav_w) && !in_act_w;
    wire        in_trs_w  = (h_r < TRS_LEN) || in_sav_w;
    wire [11:0] apos_w    = h_r - act_w;
    wire        is_y_w    = apos_w[0];
    wire        is_cr_w   = apos_w[1];

    // 75% bar values, switched hard at each bar edge.
    function automatic logic [9:0] bar_val(input logic [2:0] b, input logic y, input logic cr);
        logic [29:0] ycc;
        ycc = 30'h0;
        unique case (b)
            3'h0: ycc = {10'h2D0, 10'h200, 10'h200};
            3'h1: ycc = {10'h288, 10'h0B0, 10'h238};
            3'h2: ycc = {10'h20C, 10'h270, 10'h0B0};
            3'h3: ycc = {10'h1C0, 10'h120, 10'h0E8};
            3'h4: ycc = {10'h150, 10'h2E0, 10'h318};
            3'h5: ycc = {10'h104, 10'h190, 10'h350};
            3'h6: ycc = {10'h08C, 10'h350, 10'h1C8};
            3'h7: ycc = {10'h040, 10'h200, 10'h200};
        endcase
        return y ? ycc[29:20] : (cr ? ycc[9:0] : ycc[19:10]);
    endfunction

    // Active-video word for the four full-field patterns.
    logic [9:0] act_word_w;
    always_comb
    begin
        act_word_w = BLACK_C;
        unique case (mode.pat)
            PAT_BLACK: act_word_w = is_y_w ? BLACK_Y : BLACK_C;
            PAT_PLL:   act_word_w = is_y_w ? PLL_Y : PLL_C;
            PAT_EQ:    act_word_w = is_y_w ? EQ_Y : EQ_C;
            PAT_BARS:  act_word_w = bar_val(bar_r, is_y_w, is_cr_w);
        endcase
    end

    // Timing reference words, blanking, or active picture.
    wire [9:0] trs_w = (h_r[1:0] == 2'h0) ? TRS_ONES
                     : (h_r[1:0] == 2'h3) ? (in_sav_w ? XYZ_SAV : XYZ_EAV) : TRS_ZERO;
    wire [9:0] word_nxt = in_trs_w ? trs_w : in_act_w ? act_word_w
                        : (h_r[0] ? BLACK_Y : BLACK_C);

    // Line, field and bar position counters.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            h_r         <= 12'h000;
            v_r         <= 10'h000;
            bar_r       <= 3'h0;
            barc_r      <= 8'h00;
            word_r      <= BLACK_C;
            field_end_r <= 1'b0;
        end
        else
        begin
            h_r         <= h_last_w ? 12'h000 : h_r + 12'h001;
            v_r         <= !h_last_w ? v_r : (v_last_w ? 10'h000 : v_r + 10'h001);
            barc_r      <= (!in_act_w || barc_r == barw_w - 8'h01) ? 8'h00 : barc_r + 8'h01;
            bar_r       <= !in_act_w ? 3'h0 : (barc_r == barw_w - 8'h01) ? bar_r + 3'h1 : bar_r;
            word_r      <= word_nxt;
            field_end_r <= h_last_w && v_last_w;
        end
    end
endmodule // vtp_pattern_gen
`default_nettype wire

// ===== src/vtp_top.sv
// Purpose: Self check and test pattern generator of a serial video encoder.
// Assumes: aclk is the parallel word clock; a 10x serializer follows.
// Notes:   Registers sit behind an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module vtp_top #(
    parameter int unsigned LINES_NTSC = 262,
    parameter int unsigned LINES_PAL  = 312
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [vtp_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output var  logic                        s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output var  logic                        s_axi_wready,
    output var  logic [1:0]                  s_axi_bresp,
    output var  logic                        s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [vtp_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output var  logic                        s_axi_arready,
    output var  logic [31:0]                 s_axi_rdata,
    output var  logic [1:0]                  s_axi_rresp,
    output var  logic                        s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic [vtp_pkg::WORD_W-1:0]  parallel_data,
    input  wire logic                        pattern_gen_enable_in,
    input  wire logic                        pll_lock_in,
    output var  logic                        lock_detect,
    output var  logic                        test_out,
    output var  vtp_pkg::vtp_pair_t          serial_out_pair,
    output var  logic                        serial_out_en
);
    import vtp_pkg::*;

    typedef enum logic {ST_IDLE, ST_RUN} vtp_state_t;

    vtp_state_t  state_r;
    logic [11:0] sync1_r;
    logic [11:0] sync2_r;
    logic        ctrl_en_r;
    logic        ctrl_sel_r;
    logic [3:0]  ctrl_code_r;
    vtp_mode_t   mode_r;
    logic        self_r;
    logic [9:0]  in_reg_r;
    logic [9:0]  exp1_r;
    logic [9:0]  exp2_r;
    vtp_scr_t    scr_r;
    vtp_scr_t    dsc_r;
    logic [2:0]  warm_r;
    logic        err_r;
    logic [15:0] errcnt_r;
    logic [15:0] fields_r;
    logic        aw_h_r;
    logic        w_h_r;
    logic [7:0]  waddr_r;
    logic [31:0] wdata_r;
    logic        wstrb0_r;
    logic [9:0]  gen_word;
    logic        gen_field;

    // Pin side: data, enable and lock pass two flops before use.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 12'h000;
            sync2_r <= 12'h000;
        end
        else
        begin
            sync1_r <= {pll_lock_in, pattern_gen_enable_in, parallel_data};
            sync2_r <= sync1_r;
        end
    end

    // Mode decode; only the low four data bits form the pin code.
    wire [9:0] pin_data_w = sync2_r[9:0];
    wire [3:0] pin_code_w = pin_data_w[3:0];
    wire       en_w       = sync2_r[10] || ctrl_en_r;
    wire       lock_w     = sync2_r[11];
    wire [3:0] code_w     = ctrl_sel_r ? ctrl_code_r : pin_code_w;
    wire       self_w     = (code_w == CODE_CHK_NTSC) || (code_w == CODE_CHK_PAL);
    wire       start_w    = (state_r == ST_IDLE) && en_w && lock_w;
    wire       stop_w     = (state_r == ST_RUN) && !en_w;
    wire       run_w      = (state_r == ST_RUN);

    // Mode state: the code is caught on entry and held until the next entry.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ST_IDLE;
            mode_r  <= '0;
            self_r  <= 1'b0;
        end
        else if (start_w)
        begin
            state_r <= ST_RUN;
            mode_r  <= vtp_mode_t'(code_w);
            self_r  <= self_w;
        end
        else if (stop_w)
        begin
            state_r <= ST_IDLE;
            self_r  <= 1'b0;
        end
    end

    vtp_pattern_gen #(
        .LINES_NTSC (LINES_NTSC),
        .LINES_PAL  (LINES_PAL)
    ) u_gen (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .run         (run_w),
        .mode        (mode_r),
        .word_r      (gen_word),
        .field_end_r (gen_field)
    );

    // Scramble with x^9+x^4+1 and convert to NRZI, LSB first.
    function automatic vtp_scr_t scramble(input vtp_scr_t s, input logic [9:0] d);
        vtp_scr_t o;
        logic     y;
        o = s;
        y = 1'b0;
        for (int i = 0; i < WORD_W; i++)
        begin
            y         = d[i] ^ o.hist[3] ^ o.hist[8];
            o.hist    = {o.hist[7:0], y};
            o.last    = o.last ^ y;
            o.word[i] = o.last;
        end
        return o;
    endfunction

    // Undo NRZI and the scrambler on the encoded stream.
    function automatic vtp_scr_t descramble(input vtp_scr_t s, input logic [9:0] z);
        vtp_scr_t o;
        logic     y;
        o = s;
        y = 1'b0;
        for (int i = 0; i < WORD_W; i++)
        begin
            y         = z[i] ^ o.last;
            o.last    = z[i];
            o.word[i] = y ^ o.hist[3] ^ o.hist[8];
            o.hist    = {o.hist[7:0], y};
        end
        return o;
    endfunction

    wire vtp_scr_t scr_nxt = scramble(scr_r, in_reg_r);
    wire vtp_scr_t dsc_nxt = descramble(dsc_r, scr_r.word);

    // Input register takes pattern words while running, else pin data.
    // The scrambler state advances while locked and holds when not; the serial output still follows the input.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_reg_r <= 10'h000;
            exp1_r   <= 10'h000;
            exp2_r   <= 10'h000;
            scr_r    <= '0;
            dsc_r    <= '0;
        end
        else
        begin
            in_reg_r <= run_w ? gen_word : pin_data_w;
            exp1_r   <= in_reg_r;
            exp2_r   <= exp1_r;
            scr_r    <= lock_w ? scr_nxt : scr_r;
            dsc_r    <= dsc_nxt;
        end
    end

    // Checker: compare recovered words with the injected ones.
    wire chk_ok_w = run_w && self_r && (warm_r == WARM_WORDS);
    wire miss_w   = chk_ok_w && (dsc_r.word != exp2_r);
    wire pass_w   = chk_ok_w && !err_r && !miss_w && (fields_r >= PASS_FIELDS);

    // Error latch, counters and pass flag; all restart at each entry.
    always_ff @(posedge aclk)
    begin
        if (!aresetn || start_w)
        begin
            warm_r   <= 3'h0;
            err_r    <= 1'b0;
            errcnt_r <= 16'h0000;
            fields_r <= 16'h0000;
            test_out <= 1'b0;
        end
        else
        begin
            warm_r   <= (run_w && self_r && warm_r != WARM_WORDS) ? warm_r + 3'h1 : warm_r;
            err_r    <= err_r || miss_w;
            errcnt_r <= miss_w ? errcnt_r + 16'h0001 : errcnt_r;
            fields_r <= (run_w && gen_field) ? fields_r + 16'h0001 : fields_r;
            test_out <= pass_w || (test_out && run_w && !miss_w);
        end
    end

    // Serial outputs: true and complement words, enabled while locked.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            serial_out_pair <= '0;
            serial_out_en   <= 1'b0;
            lock_detect     <= 1'b0;
        end
        else
        begin
            serial_out_pair <= {scr_nxt.word, ~scr_nxt.word};
            serial_out_en   <= lock_w;
            lock_detect     <= lock_w;
        end
    end

    // Bus write side: address and data are held until both arrive.
    wire aw_take_w = s_axi_awvalid && s_axi_awready;
    wire w_take_w  = s_axi_wvalid && s_axi_wready;
    wire wr_go_w   = aw_h_r && w_h_r && !s_axi_bvalid;
    wire b_done_w  = s_axi_bvalid && s_axi_bready;
    wire wr_ctrl_w = wr_go_w && (waddr_r == REG_CTRL);
    wire wr_ro_w   = (waddr_r == REG_STATUS) || (waddr_r == REG_ERRCNT) || (waddr_r == REG_FIELDS);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_h_r        <= 1'b0;
            w_h_r         <= 1'b0;
            waddr_r       <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb0_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else if (b_done_w)
        begin
            aw_h_r        <= 1'b0;
            w_h_r         <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
        else
        begin
            s_axi_awready <= !aw_h_r && !aw_take_w;
            s_axi_wready  <= !w_h_r && !w_take_w;
            aw_h_r        <= aw_h_r || aw_take_w;
            w_h_r         <= w_h_r || w_take_w;
            waddr_r       <= aw_take_w ? s_axi_awaddr : waddr_r;
            wdata_r       <= w_take_w ? s_axi_wdata : wdata_r;
            wstrb0_r      <= w_take_w ? s_axi_wstrb[0] : wstrb0_r;
            s_axi_bvalid  <= s_axi_bvalid || wr_go_w;
            s_axi_bresp   <= wr_go_w ? ((wr_ctrl_w || wr_ro_w) ? RESP_OKAY : RESP_SLVERR) : s_axi_bresp;
        end
    end

    // Control register: software enable, code source and code.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_en_r   <= 1'b0;
            ctrl_sel_r  <= 1'b0;
            ctrl_code_r <= 4'h0;
        end
        else if (wr_ctrl_w && wstrb0_r)
        begin
            ctrl_en_r   <= wdata_r[CTRL_EN_BIT];
            ctrl_sel_r  <= wdata_r[CTRL_SEL_BIT];
            ctrl_code_r <= wdata_r[CTRL_CODE_LSB +: CODE_W];
        end
    end

    // Bus read side: decode and mux, answered one cycle after the address.
    wire [31:0] ctrl_rd_w = {24'h000000, ctrl_code_r, 2'h0, ctrl_sel_r, ctrl_en_r};
    wire [31:0] stat_rd_w = {20'h00000, mode_r, 3'h0, err_r, test_out, self_r, run_w, lock_w};
    wire        rd_ctrl_w = (s_axi_araddr == REG_CTRL);
    wire        rd_stat_w = (s_axi_araddr == REG_STATUS);
    wire        rd_errc_w = (s_axi_araddr == REG_ERRCNT);
    wire        rd_fld_w  = (s_axi_araddr == REG_FIELDS);
    wire        rd_hit_w  = rd_ctrl_w || rd_stat_w || rd_errc_w || rd_fld_w;
    wire [31:0] rd_data_w = rd_ctrl_w ? ctrl_rd_w
                          : rd_stat_w ? stat_rd_w
                          : rd_errc_w ? {16'h0000, errcnt_r}
                          : rd_fld_w  ? {16'h0000, fields_r} : 32'h0000_0000;
    wire        ar_take_w = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (ar_take_w)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data_w;
            s_axi_rresp   <= rd_hit_w ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end
endmodule // vtp_top
`default_nettype wire

// ===== testbench/vtp_board_model.sv
// Purpose: Board control stand-in that sets the pattern code and enable.
// Assumes: Clocked by the word clock.
// Notes:   Upper data bits sit at the pulled-down zero level.
`timescale 1ns/1ps
`default_nettype none
module vtp_board_model (
    input  wire logic                       aclk,
    input  wire logic [3:0]                 code,
    input  wire logic                       start,
    input  wire logic                       tie,
    input  wire logic                       lock_detect,
    output var  logic [vtp_pkg::WORD_W-1:0] parallel_data,
    output var  logic                       pattern_gen_enable_in
);
    // Code on bits 3:0 with bit 0 as LSB; bits 9:4 left low.
    assign parallel_data = {6'h00, code};
    // Enable waits for lock, or follows the lock flag when tied to it.
    initial pattern_gen_enable_in = 1'h0;
    always @(posedge aclk)
        pattern_gen_enable_in <= tie ? lock_detect : start && lock_detect;
endmodule // vtp_board_model
`default_nettype wire

// ===== testbench/vtp_monitor.sv
// Purpose: Port checker for vtp_top.
// Assumes: One clock domain, reset active low.
// Notes:   Counts enable-high cycles to time the pass flag.
`timescale 1ns/1ps
`default_nettype none
module vtp_monitor #(
    parameter int unsigned LINES_NTSC = 262,
    parameter int unsigned LINES_PAL  = 312
) (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic [vtp_pkg::WORD_W-1:0] parallel_data,
    input wire logic                       pattern_gen_enable_in,
    input wire logic                       pll_lock_in,
    input wire logic                       lock_detect,
    input wire logic                       test_out,
    input wire vtp_pkg::vtp_pair_t         serial_out_pair,
    input wire logic                       serial_out_en,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready
);
    import vtp_pkg::*;
    localparam int unsigned FMIN = 2 * LINES_NTSC * 1716;
    localparam int unsigned FMAX = 2 * LINES_PAL * 1728 + 64;
    logic [23:0] en_cnt_r;
    logic [3:0]  code_r;
    logic        chk_code;
    // A latched self-check code is the only road to a pass.
    assign chk_code = code_r == CODE_CHK_NTSC || code_r == CODE_CHK_PAL;
    // Enable-high run length, and the code seen as enable rises.
    always_ff @(posedge aclk)
    begin
        en_cnt_r <= (!aresetn || !pattern_gen_enable_in) ? 24'h000000 : en_cnt_r + 24'h000001;
        if (en_cnt_r == 24'h000000) code_r <= parallel_data[3:0];
    end
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Lock, serial stream, pass flag and read handshake relations.
    a_lock_follows:
        assert property ($stable(pll_lock_in) [*4] |-> lock_detect == pll_lock_in)
        else $error("lock flag wrong");
    a_pair_compl:
        assert property ($changed(serial_out_pair) |-> serial_out_pair.n == ~serial_out_pair.p)
        else $error("serial pair not complementary");
    a_serial_runs:
        assert property (serial_out_en && pattern_gen_enable_in |-> ##[1:16] $changed(serial_out_pair.p))
        else $error("serial data stalled");
    a_stop_clears:
        assert property (!pattern_gen_enable_in [*6] |-> !test_out)
        else $error("pass flag outlived enable");
    a_pass_late:
        assert property ($rose(test_out) |-> en_cnt_r >= FMIN)
        else $error("pass flag rose early");
    a_pass_on_time:
        assert property (en_cnt_r == FMAX && chk_code && lock_detect |-> test_out)
        else $error("pass flag missing");
    a_pass_code:
        assert property (test_out && pattern_gen_enable_in |-> chk_code)
        else $error("pass flag on a plain pattern");
    a_read_done:
        assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data held after handshake");
    c_pass: cover property ($rose(test_out));
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_full: cover property (en_cnt_r == FMAX && chk_code);
endmodule // vtp_monitor
bind vtp_top vtp_monitor #(.LINES_NTSC(LINES_NTSC), .LINES_PAL(LINES_PAL)) u_mon (
    .aclk(aclk), .aresetn(aresetn), .parallel_data(parallel_data), .pattern_gen_enable_in(pattern_gen_enable_in),
    .pll_lock_in(pll_lock_in), .lock_detect(lock_detect), .test_out(test_out), .serial_out_pair(serial_out_pair),
    .serial_out_en(serial_out_en), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== testbench/vtp_top_tb.sv
// Purpose: Self-checking bench for vtp_top.
// Assumes: 25 MHz aclk and short field counts.
// Notes:   Reads are scored against a queue of expected words.
`timescale 1ns/1ps
`default_nettype none
module vtp_top_tb;
    import vtp_pkg::*;
    localparam int unsigned LN = 4;
    logic              aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic              arvalid = 1'h0, rready = 1'h0, pll_lock = 1'h0, start = 1'h0, tie = 1'h0;
    logic              awready, wready, bvalid, arready, rvalid, lock_detect, test_out, sout_en, pg_en;
    logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]       wdata = 32'h0, rdata, wd;
    logic [1:0]        bresp, rresp;
    logic [3:0]        code = 4'h0;
    logic [WORD_W-1:0] pdata;
    vtp_pair_t         pair;
    logic [33:0]       exp_q[$];
    int                err_count = 0, n_compared = 0, seed = 9, i, k;
    // Free-running word clock.
    always #20 aclk = ~aclk;
    vtp_top #(.LINES_NTSC(LN), .LINES_PAL(LN)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .parallel_data(pdata), .pattern_gen_enable_in(pg_en), .pll_lock_in(pll_lock),
        .lock_detect(lock_detect), .test_out(test_out), .serial_out_pair(pair), .serial_out_en(sout_en));
    vtp_board_model u_board (.aclk(aclk), .code(code), .start(start), .tie(tie), .lock_detect(lock_detect),
        .parallel_data(pdata), .pattern_gen_enable_in(pg_en));
    // Compares one result and reports a mismatch at once.
    task automatic chk(input logic [33:0] act, input logic [33:0] exp);
        n_compared++;
        if (act !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, act, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Write: address and data offered together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'h1;
        w = 1'h1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            aw &= awready !== 1'h1;
            w &= wready !== 1'h1;
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk({32'h0, bresp}, {32'h0, er});
        @(posedge aclk);
    endtask
    // Read: the expected word is queued before the request goes out.
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        @(posedge aclk);
    endtask
    // Scores each read handshake against the oldest queued word.
    always @(posedge aclk)
        if (rvalid === 1'h1 && rready === 1'h1) chk({rresp, rdata}, exp_q.pop_front());
    // One pattern run: lock cycled, code changed mid-run, then stopped.
    task automatic run(input logic [3:0] c, input logic t, input logic full);
        logic sc;
        sc = c == CODE_CHK_NTSC || c == CODE_CHK_PAL;
        pll_lock <= 1'h0;
        code <= c;
        tie <= t;
        start <= ~t;
        repeat (6) @(posedge aclk);
        pll_lock <= 1'h1;
        repeat (40) @(posedge aclk);
        code <= ~c;
        for (i = 0; full && test_out !== 1'h1 && i < 2 * LN * 1728 + 200; i++) @(posedge aclk);
        if (full) chk({33'h0, test_out}, 34'h1);
        if (full) rd(REG_ERRCNT, 34'h0);
        rd(REG_STATUS, {22'h0, c, 4'h0, full & sc, sc, 2'h3});
        // Hold a passing test past the latest pass time; the flag must stay up.
        if (full) repeat (200) @(posedge aclk);
        if (full) chk({33'h0, test_out}, 34'h1);
        start <= 1'h0;
        tie <= 1'h0;
        repeat (8) @(posedge aclk);
        chk({33'h0, test_out}, 34'h0);
    endtask
    // Reset, register map, every pattern code, then two full self checks.
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        rd(REG_CTRL, 34'h0);
        wd = $random(seed) & 32'h0000_00F2;
        wr(REG_CTRL, wd, RESP_OKAY);
        rd(REG_CTRL, {2'h0, wd});
        wr(REG_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        rd(REG_STATUS, 34'h0);
        wr(8'h10, 32'h0000_0001, RESP_SLVERR);
        rd(8'h10, {RESP_SLVERR, 32'h0});
        wr(REG_CTRL, 32'h0, RESP_OKAY);
        for (k = 0; k < 16; k++) run(k[3:0], k[0], 1'h0);
        run(CODE_CHK_NTSC, 1'h0, 1'h1);
        run(CODE_CHK_PAL, 1'h1, 1'h1);
        // Software enable with the code taken from the control register.
        wr(REG_CTRL, 32'h0000_00E3, RESP_OKAY);
        rd(REG_STATUS, 34'h00E03);
        summarize();
    end
    // Cuts a hang short well past the expected run length.
    initial
    begin
        #(40 * 60000);
        err_count++;
        summarize();
    end
endmodule // vtp_top_tb
`default_nettype wire
